// file: core/fblw_consts.svh
// constant definitions for the fieldbus link watchdog register block
`ifndef FBLW_CONSTS_SVH
`define FBLW_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define FBLW_OFF_CTRL 12'h000
`define FBLW_OFF_STATUS_WORD 12'h004
`define FBLW_OFF_CMD_WORD 12'h008
`define FBLW_OFF_SETPOINT 12'h00C
`define FBLW_OFF_FREQ 12'h010
`define FBLW_OFF_PWR_LO 12'h014
`define FBLW_OFF_PWR_HI 12'h018
`define FBLW_OFF_IRQ_STAT 12'h01C
`define FBLW_OFF_IRQ_MASK 12'h020
`define FBLW_OFF_LINK 12'h024

// ************************************************************
// field positions and values
// ************************************************************
`define FBLW_CTRL_ACC_LSB 0
`define FBLW_CTRL_PROTO_LSB 2
`define FBLW_ACC_RW 2'h2
`define FBLW_IRQ_TIMEOUT 0
`define FBLW_IRQ_CLOSE 1
`define FBLW_IRQ_CLEARED 2
`define FBLW_SP_MAX 16'h03FF
`define FBLW_RESET_WORD 16'h0000

// ************************************************************
// timing
// ************************************************************
`define FBLW_TIMEOUT_S 35
`define FBLW_CLK_HZ 100000000
`define FBLW_TIMEOUT_CYC (64'(`FBLW_TIMEOUT_S) * 64'(`FBLW_CLK_HZ))

`endif

// file: core/fblw_pkg.sv
// types for the fieldbus link watchdog register block
package fblw_pkg;

  typedef enum logic [1:0] {
    FBLW_PROTO_TCP,
    FBLW_PROTO_PROFIBUS,
    FBLW_PROTO_PROFINET,
    FBLW_PROTO_UNWATCHED
  } fblw_proto_t;

  typedef enum logic [1:0] {
    FBLW_ACC_OFF,
    FBLW_ACC_RO,
    FBLW_ACC_RW_MODE,
    FBLW_ACC_RSVD
  } fblw_access_t;

  typedef enum logic [1:0] {
    FBLW_WD_IDLE,
    FBLW_WD_WATCH,
    FBLW_WD_EXPIRE
  } fblw_wd_state_t;

endpackage : fblw_pkg

// file: core/fblw_watchdog.sv
// link watchdog counter and expiry state machine
`include "fblw_consts.svh"

module fblw_watchdog #(
  parameter logic [63:0] TIMEOUT_CYC = `FBLW_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic conn_open,
  input wire logic msg_valid,
  output logic expire_timeout,
  output logic expire_close
);

  fblw_pkg::fblw_wd_state_t state_q;
  fblw_pkg::fblw_wd_state_t state_d;
  logic [63:0] cnt_q;
  logic [63:0] cnt_d;
  logic tmo_d;
  logic cls_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    tmo_d = 1'b0;
    cls_d = 1'b0;
    case (state_q)
      fblw_pkg::FBLW_WD_IDLE:
      begin
        cnt_d = 64'h0;
        if (enable && conn_open)
        begin
          state_d = fblw_pkg::FBLW_WD_WATCH;
        end
      end
      fblw_pkg::FBLW_WD_WATCH:
      begin
        // R10: disabled watchdog
        if (!enable)
        begin
          state_d = fblw_pkg::FBLW_WD_IDLE;
        end
        // R8: close clears
        else if (!conn_open)
        begin
          cls_d = 1'b1;
          state_d = fblw_pkg::FBLW_WD_IDLE;
        end
        // R13: restart on message
        else if (msg_valid)
        begin
          cnt_d = 64'h0;
        end
        // R8: gap exceeds timeout
        else if (cnt_q >= TIMEOUT_CYC - 64'h1)
        begin
          tmo_d = 1'b1;
          state_d = fblw_pkg::FBLW_WD_EXPIRE;
        end
        else
        begin
          cnt_d = cnt_q + 64'h1;
        end
      end
      fblw_pkg::FBLW_WD_EXPIRE:
      begin
        cnt_d = 64'h0;
        if (!enable)
        begin
          state_d = fblw_pkg::FBLW_WD_IDLE;
        end
        // R8: close clears again
        else if (!conn_open)
        begin
          cls_d = 1'b1;
          state_d = fblw_pkg::FBLW_WD_IDLE;
        end
        else if (msg_valid)
        begin
          state_d = fblw_pkg::FBLW_WD_WATCH;
        end
      end
      default:
      begin
        state_d = fblw_pkg::FBLW_WD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= fblw_pkg::FBLW_WD_IDLE;
      cnt_q <= 64'h0;
      expire_timeout <= 1'b0;
      expire_close <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      expire_timeout <= tmo_d;
      expire_close <= cls_d;
    end
  end

  // R13: counter idle when unwatched
  chk_idle_count_zero: assert property (@(posedge mclk) disable iff (!resetn) // R13
    (state_q == fblw_pkg::FBLW_WD_IDLE) |=> (cnt_q == 64'h0))
    else $error("counter runs while idle");

  // R13: message restarts interval
  chk_msg_restart: assert property (@(posedge mclk) disable iff (!resetn) // R13
    (state_q == fblw_pkg::FBLW_WD_WATCH) && enable && conn_open && msg_valid |=> (cnt_q == 64'h0))
    else $error("message did not restart interval");

  // R10: no expiry when disabled
  chk_disabled_no_expire: assert property (@(posedge mclk) disable iff (!resetn) // R10
    !enable |=> !expire_timeout && !expire_close)
    else $error("expiry while disabled");

endmodule : fblw_watchdog

// file: core/fblw_regs.sv
// apb register bank with fieldbus link watchdog
`include "fblw_consts.svh"

// Operation
// R1: every parameter register holds a 16-bit unsigned value
// R2: wide values such as total power span two consecutive registers
// R3: frequency reported as hundredths, value equals frequency times 100
// R4: set-point zero to full scale encoded 0 to 1023
// R5: status word gives one bit per alarm, input or feature state
// R6: host changes one command bit by read-modify-write
// R7: master messages at most 35 seconds apart on watched links
// R8: timeout or closed connection clears all holding registers to zero
// R9: modbus rtu and ethernet/ip sessions are not watched
// R10: watchdog off while secondary port access is off
// R11: command word zero selects analog set-point and current-limit sources
// R12: host writes accepted only with read-and-write access; only command word and set-point writes are refused without it here
// R13: interval counter restarts on each message, runs only while connected
module fblw_regs #(
  parameter logic [63:0] TIMEOUT_CYC = `FBLW_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] status_in,
  input wire logic [15:0] freq_hundredths,
  input wire logic [31:0] total_power_sum,
  input wire logic link_open,
  input wire logic link_msg,
  output logic [15:0] cmd_word,
  output logic [15:0] setpoint,
  output logic sp_from_analog,
  output logic ilim_from_analog,
  output logic irq
);

  // ************************************************************
  // state
  // ************************************************************
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [15:0] sp_q;
  logic [15:0] sp_d;
  logic [2:0] ista_q;
  logic [2:0] ista_d;
  logic [2:0] imask_q;
  logic [2:0] imask_d;
  logic [31:0] prdata_d;
  logic pslverr_d;
  logic pready_q;
  logic pready_d;
  logic analog_d;
  logic irq_d;
  logic wd_enable;
  logic wd_tmo;
  logic wd_cls;
  logic wd_clear;
  logic wr_en;
  logic rd_en;
  logic [2:0] ev;

  fblw_pkg::fblw_access_t acc;
  fblw_pkg::fblw_proto_t proto;

  assign acc = fblw_pkg::fblw_access_t'(ctrl_q[`FBLW_CTRL_ACC_LSB +: 2]);
  assign proto = fblw_pkg::fblw_proto_t'(ctrl_q[`FBLW_CTRL_PROTO_LSB +: 2]);

  function automatic logic mapped(input logic [11:0] a);
    case (a)
      `FBLW_OFF_CTRL, `FBLW_OFF_STATUS_WORD, `FBLW_OFF_CMD_WORD, `FBLW_OFF_SETPOINT,
      `FBLW_OFF_FREQ, `FBLW_OFF_PWR_LO, `FBLW_OFF_PWR_HI, `FBLW_OFF_IRQ_STAT,
      `FBLW_OFF_IRQ_MASK, `FBLW_OFF_LINK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic logic is_holding(input logic [11:0] a);
    is_holding = (a == `FBLW_OFF_CMD_WORD) || (a == `FBLW_OFF_SETPOINT);
  endfunction : is_holding

  // ************************************************************
  // watchdog
  // ************************************************************
  // R9: unwatched protocols skip the watchdog
  // R10: access off disables it
  assign wd_enable = (proto != fblw_pkg::FBLW_PROTO_UNWATCHED) && (acc != fblw_pkg::FBLW_ACC_OFF);

  fblw_watchdog #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_wd (
    .mclk(mclk),
    .resetn(resetn),
    .enable(wd_enable),
    .conn_open(link_open),
    .msg_valid(link_msg),
    .expire_timeout(wd_tmo),
    .expire_close(wd_cls)
  );

  assign wd_clear = wd_tmo || wd_cls;

  // ************************************************************
  // apb access, one wait state
  // ************************************************************
  assign wr_en = psel && penable && pready_q && pwrite;
  assign rd_en = psel && penable && !pready_q && !pwrite;
  assign ev = {wd_clear, wd_cls, wd_tmo};

  always_comb
  begin
    ctrl_d = ctrl_q;
    cmd_d = cmd_q;
    sp_d = sp_q;
    imask_d = imask_q;
    ista_d = ista_q;
    prdata_d = prdata;
    pslverr_d = 1'b0;
    if (psel && penable && !pready_q)
    begin
      pslverr_d = !mapped(paddr) || (pwrite && is_holding(paddr) && acc != fblw_pkg::FBLW_ACC_RW_MODE);
    end
    if (rd_en)
    begin
      prdata_d = 32'h0;
      case (paddr)
        `FBLW_OFF_CTRL: prdata_d = {28'h0, ctrl_q};
        // R5: one bit per state
        `FBLW_OFF_STATUS_WORD: prdata_d = {16'h0, status_in};
        // R6: command word reads back for read-modify-write
        `FBLW_OFF_CMD_WORD: prdata_d = {16'h0, cmd_q};
        `FBLW_OFF_SETPOINT: prdata_d = {16'h0, sp_q};
        // R3: hundredths of a hertz
        `FBLW_OFF_FREQ: prdata_d = {16'h0, freq_hundredths};
        // R2: low word then high word
        `FBLW_OFF_PWR_LO: prdata_d = {16'h0, total_power_sum[15:0]};
        `FBLW_OFF_PWR_HI: prdata_d = {16'h0, total_power_sum[31:16]};
        `FBLW_OFF_IRQ_STAT: prdata_d = {29'h0, ista_q};
        `FBLW_OFF_IRQ_MASK: prdata_d = {29'h0, imask_q};
        `FBLW_OFF_LINK: prdata_d = {30'h0, wd_enable, link_open};
        default: prdata_d = 32'h0;
      endcase
    end
    if (wr_en && !pslverr)
    begin
      case (paddr)
        `FBLW_OFF_CTRL: ctrl_d = pwdata[3:0];
        // R12: holding writes need read-and-write access
        // R1: sixteen bit values
        `FBLW_OFF_CMD_WORD: cmd_d = pwdata[15:0];
        // R4: set-point clamped to 1023 full scale
        `FBLW_OFF_SETPOINT: sp_d = (pwdata[15:0] > `FBLW_SP_MAX) ? `FBLW_SP_MAX : pwdata[15:0];
        `FBLW_OFF_IRQ_STAT: ista_d = ista_q & ~pwdata[2:0];
        `FBLW_OFF_IRQ_MASK: imask_d = pwdata[2:0];
        default: ctrl_d = ctrl_q;
      endcase
    end
    // R8: expiry zeroes holding registers
    if (wd_clear)
    begin
      cmd_d = `FBLW_RESET_WORD;
      sp_d = `FBLW_RESET_WORD;
    end
    // events win over clear
    ista_d = ista_d | ev;
    pready_d = psel && penable && !pready_q;
    // R11: zero command selects analog
    analog_d = (cmd_d == `FBLW_RESET_WORD);
    irq_d = |(ista_d & imask_d);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= 4'h0;
      cmd_q <= `FBLW_RESET_WORD;
      sp_q <= `FBLW_RESET_WORD;
      ista_q <= 3'h0;
      imask_q <= 3'h0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready_q <= 1'b0;
      pready <= 1'b0;
      cmd_word <= `FBLW_RESET_WORD;
      setpoint <= `FBLW_RESET_WORD;
      sp_from_analog <= 1'b1;
      ilim_from_analog <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cmd_q <= cmd_d;
      sp_q <= sp_d;
      ista_q <= ista_d;
      imask_q <= imask_d;
      prdata <= prdata_d;
      pslverr <= pslverr_d;
      pready_q <= pready_d;
      pready <= pready_d;
      cmd_word <= cmd_d;
      setpoint <= sp_d;
      sp_from_analog <= analog_d;
      ilim_from_analog <= analog_d;
      irq <= irq_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_expire;
    wd_tmo || wd_cls;
  endsequence

  sequence s_access_first;
    psel && penable && !pready;
  endsequence

  sequence s_cmd_write;
    s_access_first && pwrite && (paddr == `FBLW_OFF_CMD_WORD) && (acc == fblw_pkg::FBLW_ACC_RW_MODE) ##1
    psel && penable && pready && pwrite && (paddr == `FBLW_OFF_CMD_WORD) && !wd_clear;
  endsequence

  sequence s_sp_over_write;
    s_access_first && pwrite && (paddr == `FBLW_OFF_SETPOINT) && (acc == fblw_pkg::FBLW_ACC_RW_MODE) ##1
    psel && penable && pready && pwrite && (paddr == `FBLW_OFF_SETPOINT) && (pwdata[15:0] > `FBLW_SP_MAX) &&
    !wd_clear;
  endsequence

  // R8: expiry clears holding
  chk_expire_clears_cmd: assert property (@(posedge mclk) disable iff (!resetn) // R8
    s_expire |=> (cmd_q == 16'h0000) && (sp_q == 16'h0000))
    else $error("holding registers not cleared");

  // R11: zero command analog
  chk_zero_cmd_analog: assert property (@(posedge mclk) disable iff (!resetn) // R11
    (cmd_q == 16'h0000) |-> sp_from_analog && ilim_from_analog)
    else $error("zero command not analog");

  // R11: nonzero command remote
  chk_cmd_remote: assert property (@(posedge mclk) disable iff (!resetn) // R11
    (cmd_q != 16'h0000) |-> !sp_from_analog && !ilim_from_analog)
    else $error("nonzero command still analog");

  // R4: set-point full scale
  chk_setpoint_range: assert property (@(posedge mclk) disable iff (!resetn) // R4
    sp_q <= 16'h03FF)
    else $error("setpoint above full scale");

  // R4: oversize write clamps
  chk_setpoint_clamp: assert property (@(posedge mclk) disable iff (!resetn) // R4
    s_sp_over_write |=> (sp_q == `FBLW_SP_MAX))
    else $error("setpoint not clamped");

  // R12: no write without access
  chk_write_permission: assert property (@(posedge mclk) disable iff (!resetn) // R12
    (acc != fblw_pkg::FBLW_ACC_RW_MODE) && !wd_clear ##1 $changed(cmd_q) |-> $past(wd_clear))
    else $error("command changed without write access");

  // R12: denied write errors
  chk_denied_write_err: assert property (@(posedge mclk) disable iff (!resetn) // R12
    s_access_first && pwrite && is_holding(paddr) && (ctrl_q[`FBLW_CTRL_ACC_LSB +: 2] != `FBLW_ACC_RW)
    |=> pready && pslverr)
    else $error("denied write not refused");

  // R12: granted write lands
  chk_cmd_write: assert property (@(posedge mclk) disable iff (!resetn) // R12
    s_cmd_write |=> (cmd_q == $past(pwdata[15:0])))
    else $error("command write lost");

  // R9: unwatched never clears
  chk_unwatched_no_clear: assert property (@(posedge mclk) disable iff (!resetn) // R9
    (proto == fblw_pkg::FBLW_PROTO_UNWATCHED) [*2] |-> !wd_tmo && !wd_cls)
    else $error("watchdog on unwatched protocol");

  // R10: disabled watchdog quiet
  chk_disabled_quiet: assert property (@(posedge mclk) disable iff (!resetn) // R10
    !wd_enable |=> !wd_tmo && !wd_cls)
    else $error("expiry while watchdog disabled");

  // R8: timeout sets flags
  chk_timeout_flag: assert property (@(posedge mclk) disable iff (!resetn) // R8
    wd_tmo |=> ista_q[`FBLW_IRQ_TIMEOUT] && ista_q[`FBLW_IRQ_CLEARED])
    else $error("timeout flags not set");

  // R8: close sets flags
  chk_close_flag: assert property (@(posedge mclk) disable iff (!resetn) // R8
    wd_cls |=> ista_q[`FBLW_IRQ_CLOSE] && ista_q[`FBLW_IRQ_CLEARED])
    else $error("close flags not set");

  // R3: frequency in hundredths
  chk_freq_read: assert property (@(posedge mclk) disable iff (!resetn) // R3
    rd_en && paddr == `FBLW_OFF_FREQ |=> prdata[15:0] == $past(freq_hundredths))
    else $error("frequency read mismatch");

  // R2: power high word
  chk_power_pair: assert property (@(posedge mclk) disable iff (!resetn) // R2
    rd_en && paddr == `FBLW_OFF_PWR_HI |=> prdata[15:0] == $past(total_power_sum[31:16]))
    else $error("power high word mismatch");

  // R2: power low word
  chk_power_low: assert property (@(posedge mclk) disable iff (!resetn) // R2
    rd_en && paddr == `FBLW_OFF_PWR_LO |=> prdata[15:0] == $past(total_power_sum[15:0]))
    else $error("power low word mismatch");

  // R1: sixteen bit values
  chk_upper_half_zero: assert property (@(posedge mclk) disable iff (!resetn) // R1
    prdata[31:16] == 16'h0000)
    else $error("read data wider than sixteen bits");

  // R5: status word bits
  chk_status_read: assert property (@(posedge mclk) disable iff (!resetn) // R5
    rd_en && paddr == `FBLW_OFF_STATUS_WORD |=> prdata == {16'h0, $past(status_in)})
    else $error("status word mismatch");

endmodule : fblw_regs

// file: verif/fblw_master_model.sv
// fieldbus master model driving connection state and message pulses
module fblw_master_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic open_req,
  input wire logic [7:0] gap,
  output logic link_open,
  output logic link_msg
);
  logic [7:0] cnt_q;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= 8'h00;
      link_open <= 1'b0;
      link_msg <= 1'b0;
    end
    else
    begin
      link_open <= open_req;
      link_msg <= 1'b0;
      cnt_q <= cnt_q + 8'h01;
      if (open_req && link_open && gap != 8'h00 && cnt_q >= gap)
      begin
        link_msg <= 1'b1;
        cnt_q <= 8'h00;
      end
    end
  end
endmodule : fblw_master_model

// file: verif/tb_fieldbus_link_watchdog_regs.sv
// self-checking bench for the fieldbus link watchdog register block
module tb_fieldbus_link_watchdog_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, link_open, link_msg, sp_from_analog, ilim_from_analog, irq;
  logic [15:0] status_in = 16'hA55A;
  logic [15:0] freq_hundredths = 16'h1388;
  logic [31:0] total_power_sum = 32'h000186A0;
  logic [15:0] cmd_word, setpoint;
  logic open_req = 1'b0;
  logic [7:0] gap = 8'h00;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  fblw_regs #(.TIMEOUT_CYC(64'h14)) u_dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_in(status_in), .freq_hundredths(freq_hundredths), .total_power_sum(total_power_sum),
    .link_open(link_open), .link_msg(link_msg), .cmd_word(cmd_word), .setpoint(setpoint),
    .sp_from_analog(sp_from_analog), .ilim_from_analog(ilim_from_analog), .irq(irq));
  fblw_master_model u_master (.mclk(mclk), .resetn(resetn), .open_req(open_req), .gap(gap),
    .link_open(link_open), .link_msg(link_msg));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
      error_cnt++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, xe});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, 32'h0);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    chk({31'h0, sp_from_analog & ilim_from_analog}, 32'h1);
    wr(12'h000, 32'h2, 1'b0);
    rd(12'h004, 32'h0000A55A);
    rd(12'h010, 32'h00001388);
    rd(12'h014, 32'h000086A0);
    rd(12'h018, 32'h00000001);
    wr(12'h008, 32'hFFFF00A5, 1'b0);
    rd(12'h008, 32'h000000A5);
    apb(1'b0, 12'h008, 32'h0, r, e);
    wr(12'h008, r | 32'h100, 1'b0);
    wt(2);
    chk({16'h0, cmd_word}, 32'h1A5);
    chk({31'h0, sp_from_analog | ilim_from_analog}, 32'h0);
    wr(12'h00C, 32'h1FF, 1'b0);
    rd(12'h00C, 32'h1FF);
    wr(12'h00C, 32'h400, 1'b0);
    wt(2);
    chk({16'h0, setpoint}, 32'h3FF);
    wr(12'h000, 32'h1, 1'b0);
    wr(12'h008, 32'h0, 1'b1);
    wr(12'h00C, 32'h5, 1'b1);
    rd(12'h008, 32'h1A5);
    wr(12'h0F0, 32'h1, 1'b1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_timeout();
    wr(12'h000, 32'h6, 1'b0);
    open_req <= 1'b1;
    gap <= 8'h0A;
    wt(60);
    rd(12'h008, 32'h1A5);
    rd(12'h024, 32'h3);
    gap <= 8'h00;
    wt(40);
    chk({16'h0, cmd_word}, 32'h0);
    chk({16'h0, setpoint}, 32'h0);
    chk({31'h0, sp_from_analog & ilim_from_analog}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(12'h01C, 32'h5);
    gap <= 8'h0A;
    wr(12'h020, 32'h7, 1'b0);
    wt(2);
    chk({31'h0, irq}, 32'h1);
    wr(12'h01C, 32'h7, 1'b0);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    rd(12'h01C, 32'h0);
    $display("test timeout done");
  endtask : t_timeout
  task automatic t_close();
    wr(12'h000, 32'hA, 1'b0);
    wr(12'h008, 32'h33, 1'b0);
    wt(30);
    rd(12'h008, 32'h33);
    open_req <= 1'b0;
    wt(5);
    chk({16'h0, cmd_word}, 32'h0);
    rd(12'h01C, 32'h6);
    chk({31'h0, irq}, 32'h1);
    wr(12'h01C, 32'h7, 1'b0);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    $display("test close done");
  endtask : t_close
  task automatic t_unwatched();
    wr(12'h000, 32'hE, 1'b0);
    wr(12'h008, 32'h11, 1'b0);
    open_req <= 1'b1;
    gap <= 8'd0;
    wt(40);
    rd(12'h008, 32'h11);
    rd(12'h024, 32'h1);
    open_req <= 1'b0;
    wt(5);
    chk({16'h0, cmd_word}, 32'h11);
    open_req <= 1'b1;
    wr(12'h000, 32'h2, 1'b0);
    wr(12'h008, 32'h22, 1'b0);
    wr(12'h000, 32'h0, 1'b0);
    wt(40);
    open_req <= 1'b0;
    wt(5);
    chk({16'h0, cmd_word}, 32'h22);
    rd(12'h01C, 32'h0);
    $display("test unwatched done");
  endtask : t_unwatched
  // ************************************************************
  // main sequence and timeout
  // ************************************************************
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    wt(4);
    resetn <= 1'b1;
    t_regs();
    t_timeout();
    t_close();
    t_unwatched();
    print_verdict();
  end
endmodule : tb_fieldbus_link_watchdog_regs
